//--- common/mcc_pkg.sv
// Shared constants for the multichannel capture/compare block.
`default_nettype none
package mcc_pkg;
  localparam int MCC_MAX_CH = 4;
  localparam int MCC_BYTE_W = 8;
  localparam int MCC_COUNT_W = 16;
  // Register port addresses: the subaddress register and the two subregister windows.
  localparam logic [1:0] MCC_ADDR_SUBADDR = 2'h0;
  localparam logic [1:0] MCC_ADDR_WIN0 = 2'h1;
  localparam logic [1:0] MCC_ADDR_WIN1 = 2'h2;
  // Subaddress values.
  localparam logic [7:0] MCC_SUB_STATUS = 8'h01;
  localparam logic [7:0] MCC_SUB_CHAN_BASE = 8'h02;
  localparam logic [7:0] MCC_SUB_CTRL_BASE = 8'h06;
  // Channel control subregister fields.
  localparam int MCC_CTL_W = 5;
  localparam int MCC_CTL_POL = 0;
  localparam int MCC_CTL_CAPT = 1;
  localparam int MCC_CTL_FALL = 2;
  localparam int MCC_CTL_CHEN = 3;
  localparam int MCC_CTL_IMM = 4;
  // Reset values.
  localparam logic [7:0] MCC_RST_BYTE = 8'h00;
  localparam logic [15:0] MCC_RST_COUNT = 16'h0000;
  localparam logic [4:0] MCC_RST_CTL = 5'h00;
  localparam logic [3:0] MCC_RSVD_BITS = 4'h0;
endpackage : mcc_pkg
`default_nettype wire

//--- design/mcc_channel.sv
// One capture/compare channel: active and holding registers, compare, capture and output.
`timescale 1ns/1ps
`default_nettype none
module mcc_channel
  import mcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic timer_enable_bit,
  input wire logic [MCC_COUNT_W-1:0] timer_count,
  input wire logic timer_end_count,
  input wire logic chan_in,
  input wire logic [MCC_CTL_W-1:0] ctrl,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [MCC_BYTE_W-1:0] wr_data,
  output logic [MCC_COUNT_W-1:0] active,
  output logic event_pulse,
  output logic chan_out
);
  logic [MCC_COUNT_W-1:0] active_r, active_nxt, hold_r, hold_nxt;
  logic pend_r, pend_nxt, in_prev_r, in_prev_nxt, match_prev_r, match_prev_nxt;
  logic state_r, state_nxt, out_r, out_nxt, event_r, event_nxt;
  logic match, cmp_evt, cap_evt, edge_seen, buffered;
  logic [MCC_COUNT_W-1:0] base, newv;

  always_comb begin
    match = timer_enable_bit && ctrl[MCC_CTL_CHEN] && !ctrl[MCC_CTL_CAPT] && (timer_count == active_r);
    cmp_evt = match && !match_prev_r;
    edge_seen = ctrl[MCC_CTL_FALL] ? (in_prev_r && !chan_in) : (!in_prev_r && chan_in);
    cap_evt = timer_enable_bit && ctrl[MCC_CTL_CHEN] && ctrl[MCC_CTL_CAPT] && edge_seen;
    buffered = timer_enable_bit && !ctrl[MCC_CTL_IMM];
    base = pend_r ? hold_r : active_r;
    newv = base;
    if (wr_hi) begin
      newv[15:8] = wr_data;
    end
    if (wr_lo) begin
      newv[7:0] = wr_data;
    end
    active_nxt = active_r;
    hold_nxt = hold_r;
    pend_nxt = pend_r;
    // A pending value moves in at end count, or at once if the timer is stopped.
    if (pend_r && (timer_end_count || !timer_enable_bit)) begin
      active_nxt = hold_r;
      pend_nxt = 1'b0;
    end
    if (cap_evt) begin
      active_nxt = timer_count;
    end
    if (wr_hi || wr_lo) begin
      hold_nxt = newv;
      if (buffered) begin
        pend_nxt = 1'b1;
      end else begin
        active_nxt = newv;
        pend_nxt = 1'b0;
      end
    end
    in_prev_nxt = chan_in;
    match_prev_nxt = match;
    state_nxt = state_r ^ cmp_evt;
    out_nxt = state_nxt ^ ctrl[MCC_CTL_POL];
    event_nxt = cmp_evt || cap_evt;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= MCC_RST_COUNT;
      hold_r <= MCC_RST_COUNT;
      pend_r <= 1'b0;
      in_prev_r <= 1'b0;
      match_prev_r <= 1'b0;
      state_r <= 1'b0;
      out_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      hold_r <= hold_nxt;
      pend_r <= pend_nxt;
      in_prev_r <= in_prev_nxt;
      match_prev_r <= match_prev_nxt;
      state_r <= state_nxt;
      out_r <= out_nxt;
      event_r <= event_nxt;
    end
  end

  assign active = active_r;
  assign event_pulse = event_r;
  assign chan_out = out_r;

  sequence s_buffered_write;
    (wr_hi || wr_lo) && buffered && !cap_evt && !(pend_r && timer_end_count);
  endsequence
  sequence s_end_transfer;
    pend_r && timer_end_count && timer_enable_bit && !wr_hi && !wr_lo && !cap_evt;
  endsequence

  chk_buffered_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_buffered_write |=> (active_r == $past(active_r)) && pend_r)
    else $error("buffered write reached the active register");
  chk_end_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_end_transfer |=> (active_r == $past(hold_r)) && !pend_r)
    else $error("holding value not loaded at end count");
  chk_capture_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cap_evt && !wr_hi && !wr_lo |=> (active_r == $past(timer_count)) && event_r)
    else $error("capture did not latch the count");
  chk_compare_toggle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cmp_evt |=> (state_r != $past(state_r)) && event_r)
    else $error("compare match did not toggle the output");
  chk_out_polarity: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 out_r == (state_r ^ $past(ctrl[MCC_CTL_POL])))
    else $error("channel output disagrees with polarity");
  chk_compare_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
    timer_enable_bit && ctrl[MCC_CTL_CHEN] && !ctrl[MCC_CTL_CAPT] && timer_count == active_r && !match_prev_r
    |=> event_r)
    else $error("compare match missed");
  chk_disable_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pend_r && !timer_enable_bit && !wr_hi && !wr_lo |=> (active_r == $past(hold_r)) && !pend_r)
    else $error("pending value not loaded when the timer stopped");
endmodule : mcc_channel
`default_nettype wire

//--- design/mcc_top.sv
// Multichannel capture/compare: subaddressed register access, event and overrun flags, channels.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Overrun set when event repeats before clear.
// - Clearing event flag also clears overrun.
// - Overrun flags held clear while timer disabled.
// - Upper status bits reserved, read zero.
// - Overrun status in window 0 at subaddress 01H.
// - Each channel has 16-bit high/low register.
// - Writes buffered while timer enabled and channel IMM control bit clear.
// - Buffer loads at end count or immediately.
// - Compare channel register against timer count.
// - Compare match toggles channel output.
// - Output level follows channel polarity bit.
// - Capture latches count on selected input edge.
module mcc_top
  import mcc_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [MCC_BYTE_W-1:0] reg_wdata,
  output logic [MCC_BYTE_W-1:0] reg_rdata,
  input wire logic timer_enable_bit,
  input wire logic [MCC_COUNT_W-1:0] timer_count,
  input wire logic timer_end_count,
  input wire logic [NUM_CH-1:0] chan_in,
  output logic [NUM_CH-1:0] chan_out
);
  if (NUM_CH < 1 || NUM_CH > MCC_MAX_CH) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 4");
  end

  // True when the subaddress selects channel idx of a group starting at base.
  function automatic logic sub_hit(input logic [7:0] sub, input logic [7:0] base, input int idx);
    logic [7:0] target;
    target = base + 8'(idx);
    return sub == target;
  endfunction : sub_hit

  function automatic logic [7:0] pad_flags(input logic [NUM_CH-1:0] flags);
    logic [7:0] v;
    v = MCC_RST_BYTE;
    v[NUM_CH-1:0] = flags;
    return v;
  endfunction : pad_flags

  logic [7:0] subaddr_r, subaddr_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [NUM_CH-1:0] evt_flag_r, evt_flag_nxt;
  logic [NUM_CH-1:0] ovr_r, ovr_nxt;
  logic [MCC_CTL_W-1:0] ctrl_r [NUM_CH];
  logic [MCC_CTL_W-1:0] ctrl_nxt [NUM_CH];
  logic [NUM_CH-1:0] wr_hi, wr_lo, clr, chan_event;
  logic [MCC_COUNT_W-1:0] active [NUM_CH];
  logic win0, win1;

  // Register write decode.
  always_comb begin
    win0 = reg_addr == MCC_ADDR_WIN0;
    win1 = reg_addr == MCC_ADDR_WIN1;
    subaddr_nxt = subaddr_r;
    if (reg_wr && reg_addr == MCC_ADDR_SUBADDR) begin
      subaddr_nxt = reg_wdata;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      wr_hi[i] = reg_wr && win0 && sub_hit(subaddr_r, MCC_SUB_CHAN_BASE, i);
      wr_lo[i] = reg_wr && win1 && sub_hit(subaddr_r, MCC_SUB_CHAN_BASE, i);
      clr[i] = reg_wr && win1 && subaddr_r == MCC_SUB_STATUS && reg_wdata[i];
      ctrl_nxt[i] = ctrl_r[i];
      if (reg_wr && win0 && sub_hit(subaddr_r, MCC_SUB_CTRL_BASE, i)) begin
        ctrl_nxt[i] = reg_wdata[MCC_CTL_W-1:0];
      end
    end
  end

  // Event and overrun flags; a new event wins over a clear in the same cycle.
  always_comb begin
    evt_flag_nxt = chan_event | (evt_flag_r & ~clr);
    ovr_nxt = (chan_event & evt_flag_r) | (ovr_r & ~clr);
    if (!timer_enable_bit) begin
      ovr_nxt = '0;
    end
  end

  // Register read mux, answered one cycle after the read strobe.
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = MCC_RST_BYTE;
      if (reg_addr == MCC_ADDR_SUBADDR) begin
        rdata_nxt = subaddr_r;
      end else if (subaddr_r == MCC_SUB_STATUS) begin
        if (win0) begin
          rdata_nxt = pad_flags(ovr_r);
        end else if (win1) begin
          rdata_nxt = pad_flags(evt_flag_r);
        end
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (sub_hit(subaddr_r, MCC_SUB_CHAN_BASE, i)) begin
          if (win0) begin
            rdata_nxt = active[i][15:8];
          end else if (win1) begin
            rdata_nxt = active[i][7:0];
          end
        end
        if (win0 && sub_hit(subaddr_r, MCC_SUB_CTRL_BASE, i)) begin
          rdata_nxt = {3'h0, ctrl_r[i]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      subaddr_r <= MCC_RST_BYTE;
      rdata_r <= MCC_RST_BYTE;
      evt_flag_r <= '0;
      ovr_r <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_r[i] <= MCC_RST_CTL;
      end
    end else begin
      subaddr_r <= subaddr_nxt;
      rdata_r <= rdata_nxt;
      evt_flag_r <= evt_flag_nxt;
      ovr_r <= ovr_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_r[i] <= ctrl_nxt[i];
      end
    end
  end

  assign reg_rdata = rdata_r;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    mcc_channel u_chan (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .timer_enable_bit(timer_enable_bit),
      .timer_count(timer_count),
      .timer_end_count(timer_end_count),
      .chan_in(chan_in[g]),
      .ctrl(ctrl_r[g]),
      .wr_hi(wr_hi[g]),
      .wr_lo(wr_lo[g]),
      .wr_data(reg_wdata),
      .active(active[g]),
      .event_pulse(chan_event[g]),
      .chan_out(chan_out[g])
    );

    chk_ovr_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      timer_enable_bit && chan_event[g] && evt_flag_r[g] |=> ovr_r[g])
      else $error("overrun not flagged");
    chk_ovr_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clr[g] && !chan_event[g] |=> !ovr_r[g] && !evt_flag_r[g])
      else $error("event clear left overrun set");
    chk_evt_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
      chan_event[g] |=> evt_flag_r[g] ##1 (evt_flag_r[g] || $past(clr[g])))
      else $error("event flag not sticky");
    chk_no_false_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ovr_r[g] && !(chan_event[g] && evt_flag_r[g]) |=> !ovr_r[g])
      else $error("overrun set without cause");
    chk_ovr_needs_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ovr_r[g] |-> evt_flag_r[g])
      else $error("overrun set while its event flag is clear");
    chk_evt_clear_race: assert property (@(posedge clk_sys) disable iff (!rst_b)
      chan_event[g] && clr[g] |=> evt_flag_r[g])
      else $error("event lost to a clear in the same cycle");

    // Register map per channel: each location reads back its own storage one cycle after the strobe.
    chk_chan_high_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
      reg_rd && win0 && sub_hit(subaddr_r, MCC_SUB_CHAN_BASE, g) |=> reg_rdata == $past(active[g][15:8]))
      else $error("channel high byte read back wrong");
    chk_chan_low_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
      reg_rd && win1 && sub_hit(subaddr_r, MCC_SUB_CHAN_BASE, g) |=> reg_rdata == $past(active[g][7:0]))
      else $error("channel low byte read back wrong");
    chk_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
      reg_wr && win0 && sub_hit(subaddr_r, MCC_SUB_CTRL_BASE, g) |=> ctrl_r[g] == $past(reg_wdata[MCC_CTL_W-1:0]))
      else $error("control subregister write lost");
    chk_ctrl_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
      reg_rd && win0 && sub_hit(subaddr_r, MCC_SUB_CTRL_BASE, g) |=> reg_rdata == {3'h0, $past(ctrl_r[g])})
      else $error("control subregister read wrong");
  end

  chk_ovr_disabled: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !timer_enable_bit |=> ovr_r == '0)
    else $error("overrun flags set while timer disabled");
  chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && win0 && subaddr_r == MCC_SUB_STATUS |=> reg_rdata[7:4] == MCC_RSVD_BITS)
    else $error("reserved status bits not zero");
  chk_status_window: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && win0 && subaddr_r == MCC_SUB_STATUS |=> reg_rdata == pad_flags($past(ovr_r)))
    else $error("overrun status read wrong");
  chk_high_byte_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && win0 && subaddr_r == MCC_SUB_CHAN_BASE |=> reg_rdata == $past(active[0][15:8]))
    else $error("channel high byte read wrong");

  // Locations outside the map read as zero, and read data stands until the next read.
  chk_subaddr_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == MCC_ADDR_SUBADDR |=> subaddr_r == $past(reg_wdata))
    else $error("subaddress write lost");
  chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && win0 && (subaddr_r < MCC_SUB_STATUS || subaddr_r >= MCC_SUB_CTRL_BASE + 8'(NUM_CH))
    |=> reg_rdata == MCC_RST_BYTE)
    else $error("unmapped subaddress read not zero");
  chk_unused_port: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == 2'h3 |=> reg_rdata == MCC_RST_BYTE)
    else $error("unused register port read not zero");
  chk_event_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && win1 && subaddr_r == MCC_SUB_STATUS |=> reg_rdata == pad_flags($past(evt_flag_r)))
    else $error("event status read wrong");
  chk_rdata_stands: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == $past(reg_rdata))
    else $error("read data changed without a read");
endmodule : mcc_top
`default_nettype wire

//--- sim/mcc_pin_model.sv
// Channel pin partner: drives the channel input pins a cycle after the bench asks for a level.
`timescale 1ns/1ps
`default_nettype none
module mcc_pin_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] pin_req,
  output logic [3:0] chan_in
);
  logic [3:0] chan_in_nxt;
  always_comb begin
    chan_in_nxt = pin_req;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_in <= 4'h0;
    end else begin
      chan_in <= chan_in_nxt;
    end
  end
endmodule : mcc_pin_model
`default_nettype wire

//--- sim/tb_mcc_top.sv
// Self-checking testbench for the multichannel capture/compare block.
`timescale 1ns/1ps
`default_nettype none
module tb_mcc_top;
  import mcc_pkg::*;
  logic clk_sys, rst_b, reg_wr, reg_rd, timer_enable_bit, timer_end_count;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] timer_count;
  logic [3:0] chan_in, chan_out, pin_req;
  int errors, check_count;
  mcc_top #(.NUM_CH(4)) i_mcc_top (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_enable_bit(timer_enable_bit),
    .timer_count(timer_count), .timer_end_count(timer_end_count), .chan_in(chan_in), .chan_out(chan_out));
  mcc_pin_model i_mcc_pin_model (.clk_sys(clk_sys), .rst_b(rst_b), .pin_req(pin_req), .chan_in(chan_in));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic wsub(input logic [7:0] sub, input logic [1:0] win, input logic [7:0] d);
    wr(MCC_ADDR_SUBADDR, sub);
    wr(win, d);
  endtask : wsub
  task automatic rd(input logic [7:0] sub, input logic [1:0] win, input logic [7:0] exp, input string name);
    wr(MCC_ADDR_SUBADDR, sub);
    reg_addr = win;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    check(name, {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  initial begin
    {reg_wr, reg_rd, timer_enable_bit, timer_end_count} = 4'h0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    timer_count = 16'h0100;
    pin_req = 4'h0;
    errors = 0;
    check_count = 0;
    rst_b = 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    rd(8'h01, MCC_ADDR_WIN0, 8'h00, "status reset");
    rd(8'h02, MCC_ADDR_WIN1, 8'h00, "ch0 low reset");
    wsub(8'h02, MCC_ADDR_WIN0, 8'h12);
    wsub(8'h02, MCC_ADDR_WIN1, 8'h34);
    rd(8'h02, MCC_ADDR_WIN0, 8'h12, "ch0 high direct");
    wsub(8'h05, MCC_ADDR_WIN1, 8'h9A);
    rd(8'h05, MCC_ADDR_WIN1, 8'h9A, "ch3 low direct");
    rd(8'h01, 2'h3, 8'h00, "unmapped port");
    rd(8'h0A, MCC_ADDR_WIN0, 8'h00, "unmapped subaddress");
    timer_enable_bit = 1'b1;
    wsub(8'h06, MCC_ADDR_WIN0, 8'h08);
    wsub(8'h02, MCC_ADDR_WIN1, 8'h56);
    rd(8'h02, MCC_ADDR_WIN1, 8'h34, "ch0 low held");
    @(negedge clk_sys);
    timer_end_count = 1'b1;
    @(negedge clk_sys);
    timer_end_count = 1'b0;
    rd(8'h02, MCC_ADDR_WIN1, 8'h56, "ch0 low end count");
    wsub(8'h06, MCC_ADDR_WIN0, 8'h18);
    wsub(8'h02, MCC_ADDR_WIN1, 8'h78);
    rd(8'h02, MCC_ADDR_WIN1, 8'h78, "ch0 low immediate");
    // Compare match of the full 16-bit value toggles the output once.
    timer_count = 16'h1278;
    repeat (3) @(negedge clk_sys);
    check("out match", {12'h000, chan_out}, 16'h0001);
    wsub(8'h06, MCC_ADDR_WIN0, 8'h19);
    repeat (2) @(negedge clk_sys);
    check("out polarity", {12'h000, chan_out}, 16'h0000);
    rd(8'h06, MCC_ADDR_WIN0, 8'h19, "ch0 control");
    rd(8'h01, MCC_ADDR_WIN1, 8'h01, "event flag");
    timer_count = 16'h1200;
    @(negedge clk_sys);
    timer_count = 16'h1278;
    repeat (3) @(negedge clk_sys);
    check("out second match", {12'h000, chan_out}, 16'h0001);
    rd(8'h01, MCC_ADDR_WIN0, 8'h01, "overrun ch0");
    wsub(8'h01, MCC_ADDR_WIN1, 8'h01);
    rd(8'h01, MCC_ADDR_WIN0, 8'h00, "overrun cleared");
    rd(8'h01, MCC_ADDR_WIN1, 8'h00, "event cleared");
    wsub(8'h01, MCC_ADDR_WIN0, 8'h0F);
    rd(8'h01, MCC_ADDR_WIN0, 8'h00, "status read only");
    // Channel 1 captures the count on a rising input edge.
    wsub(8'h07, MCC_ADDR_WIN0, 8'h0A);
    timer_count = 16'hABCD;
    pin_req = 4'h2;
    repeat (3) @(negedge clk_sys);
    timer_count = 16'h2222;
    rd(8'h03, MCC_ADDR_WIN0, 8'hAB, "capture high");
    rd(8'h03, MCC_ADDR_WIN1, 8'hCD, "capture low");
    pin_req = 4'h0;
    repeat (3) @(negedge clk_sys);
    rd(8'h03, MCC_ADDR_WIN1, 8'hCD, "falling ignored");
    pin_req = 4'h2;
    repeat (3) @(negedge clk_sys);
    rd(8'h01, MCC_ADDR_WIN0, 8'h02, "overrun ch1");
    // Channel 2 captures on a falling input edge only.
    wsub(8'h08, MCC_ADDR_WIN0, 8'h0E);
    pin_req = 4'h6;
    repeat (3) @(negedge clk_sys);
    rd(8'h04, MCC_ADDR_WIN0, 8'h00, "rising ignored");
    timer_count = 16'h3456;
    pin_req = 4'h2;
    repeat (3) @(negedge clk_sys);
    rd(8'h04, MCC_ADDR_WIN0, 8'h34, "fall capture high");
    rd(8'h04, MCC_ADDR_WIN1, 8'h56, "fall capture low");
    rd(8'h01, MCC_ADDR_WIN1, 8'h06, "event ch1 ch2");
    // Both bytes collect in the holding register and load when the timer stops.
    wsub(8'h05, MCC_ADDR_WIN1, 8'hBC);
    wsub(8'h05, MCC_ADDR_WIN0, 8'hDE);
    rd(8'h05, MCC_ADDR_WIN1, 8'h9A, "ch3 low held");
    timer_enable_bit = 1'b0;
    repeat (2) @(negedge clk_sys);
    rd(8'h01, MCC_ADDR_WIN0, 8'h00, "overrun disabled");
    rd(8'h05, MCC_ADDR_WIN0, 8'hDE, "ch3 high merged");
    rd(8'h05, MCC_ADDR_WIN1, 8'hBC, "ch3 low on disable");
    complete_run();
  end
endmodule : tb_mcc_top
`default_nettype wire
